// ===== rtl/uab_consts.svh
// Constants of the serial-to-AXI memory test bridge.
// Assumes a 50 MHz fabric clock and a 64-bit AXI memory slave.
`ifndef UAB_CONSTS_SVH
`define UAB_CONSTS_SVH

`define UAB_CLK_HZ      50000000
`define UAB_BAUD        115200
`define UAB_CMD_SWR     8'h01
`define UAB_CMD_SRD     8'h02
`define UAB_CMD_BWR     8'h03
`define UAB_CMD_BRD     8'h04
`define UAB_ADDR_BYTES  4
`define UAB_DATA_BYTES  8
`define UAB_BEATS       16
`define UAB_BURSTS      16
`define UAB_BURST_BYTES 32'h00000080
`define UAB_ALIGN_MASK  32'hFFFFFFF8
`define UAB_AXSIZE      3'h3
`define UAB_AXBURST     2'h1
`define UAB_FIFO_DEPTH  8

`endif

// ===== rtl/uab_pkg.sv
// Types of the serial-to-AXI memory test bridge.
// Assumes uab_consts.svh supplies the numeric constants.
package uab_pkg;
    typedef enum logic [8:0] {
        UAB_ST_IDLE = 9'h001,
        UAB_ST_ADDR = 9'h002,
        UAB_ST_DATA = 9'h004,
        UAB_ST_AW   = 9'h008,
        UAB_ST_W    = 9'h010,
        UAB_ST_B    = 9'h020,
        UAB_ST_AR   = 9'h040,
        UAB_ST_R    = 9'h080,
        UAB_ST_SEND = 9'h100
    } uab_state_t;

    typedef enum logic [1:0] {
        UAB_OP_SWR = 2'h0,
        UAB_OP_SRD = 2'h1,
        UAB_OP_BWR = 2'h2,
        UAB_OP_BRD = 2'h3
    } uab_op_t;
endpackage

// ===== rtl/uab_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes a power-of-two depth and a single clock.
`timescale 1ns/1ps
module uab_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic      [WIDTH-1:0] out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wp_ff;
    logic [AW:0]      rp_ff;
    logic [AW:0]      nxt_wp;
    logic [AW:0]      nxt_rp;
    logic             push;
    logic             pop;

    assign in_ready_out  = (wp_ff[AW-1:0] != rp_ff[AW-1:0]) || (wp_ff[AW] == rp_ff[AW]);
    assign out_valid_out = (wp_ff != rp_ff);
    assign out_data_out  = mem_ff[rp_ff[AW-1:0]];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
        nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem_ff[wp_ff[AW-1:0]] <= in_data_in;
        end
    end
endmodule // uab_fifo

// ===== rtl/uab_bridge.sv
// Serial command bridge that runs single and burst AXI memory transfers.
// Assumes an AXI slave with 64-bit data and a host that aligns addresses.
`timescale 1ns/1ps
`include "uab_consts.svh"
module uab_bridge import uab_pkg::*; #(
    parameter int CLK_HZ = `UAB_CLK_HZ,
    parameter int BAUD   = `UAB_BAUD
) (
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    input  wire logic        uart_rx_in,
    output logic             uart_tx_out,
    output logic             busy_out,
    output logic [31:0]      awaddr_out,
    output logic [7:0]       awlen_out,
    output logic [2:0]       awsize_out,
    output logic [1:0]       awburst_out,
    output logic             awvalid_out,
    input  wire logic        awready_in,
    output logic [63:0]      wdata_out,
    output logic [7:0]       wstrb_out,
    output logic             wlast_out,
    output logic             wvalid_out,
    input  wire logic        wready_in,
    input  wire logic [1:0]  bresp_in,
    input  wire logic        bvalid_in,
    output logic             bready_out,
    output logic [31:0]      araddr_out,
    output logic [7:0]       arlen_out,
    output logic [2:0]       arsize_out,
    output logic [1:0]       arburst_out,
    output logic             arvalid_out,
    input  wire logic        arready_in,
    input  wire logic [63:0] rdata_in,
    input  wire logic        rlast_in,
    input  wire logic        rvalid_in,
    output logic             rready_out
);
    localparam logic [15:0] DIV  = 16'(CLK_HZ / BAUD);
    localparam logic [15:0] HALF = 16'(CLK_HZ / BAUD / 2);

    // ------------------------------------------------------------
    // Serial receiver
    // ------------------------------------------------------------
    logic        rb_ff, nxt_rb;
    logic [15:0] rc_ff, nxt_rc;
    logic [3:0]  rn_ff, nxt_rn;
    logic [7:0]  rs_ff, nxt_rs;
    logic        rv_ff, nxt_rv;

    always_comb begin
        {nxt_rb, nxt_rc, nxt_rn, nxt_rs} = {rb_ff, rc_ff, rn_ff, rs_ff};
        nxt_rv = 1'b0;
        if (!rb_ff) begin
            if (!uart_rx_in) begin
                nxt_rb = 1'b1;
                nxt_rc = HALF;
                nxt_rn = 4'h0;
            end
        end else if (rc_ff != 16'h0000) begin
            nxt_rc = rc_ff - 16'h0001;
        end else begin
            nxt_rc = DIV - 16'h0001;
            nxt_rn = rn_ff + 4'h1;
            if (rn_ff == 4'h0) begin
                nxt_rb = !uart_rx_in;
            end else if (rn_ff <= 4'h8) begin
                nxt_rs = {uart_rx_in, rs_ff[7:1]};
            end else begin
                nxt_rb = 1'b0;
                nxt_rv = uart_rx_in;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {rb_ff, rc_ff, rn_ff, rs_ff, rv_ff} <= '0;
        end else begin
            {rb_ff, rc_ff, rn_ff, rs_ff, rv_ff} <= {nxt_rb, nxt_rc, nxt_rn, nxt_rs, nxt_rv};
        end
    end

    // ------------------------------------------------------------
    // Byte FIFO and serial transmitter
    // ------------------------------------------------------------
    logic        push_valid, push_ready, tx_valid, tb_ff, nxt_tb, line_ff, nxt_line;
    logic [7:0]  push_data, tx_data;
    logic [15:0] tc_ff, nxt_tc;
    logic [3:0]  tn_ff, nxt_tn;
    logic [9:0]  ts_ff, nxt_ts;

    uab_fifo #(.WIDTH(8), .DEPTH(`UAB_FIFO_DEPTH)) u_fifo (
        .mclk_in      (mclk_in),
        .rstn_in      (rstn_in),
        .in_data_in   (push_data),
        .in_valid_in  (push_valid),
        .in_ready_out (push_ready),
        .out_data_out (tx_data),
        .out_valid_out(tx_valid),
        .out_ready_in (!tb_ff)
    );

    always_comb begin
        {nxt_tb, nxt_tc, nxt_tn, nxt_ts, nxt_line} = {tb_ff, tc_ff, tn_ff, ts_ff, line_ff};
        if (!tb_ff) begin
            if (tx_valid) begin
                nxt_tb   = 1'b1;
                nxt_tc   = DIV - 16'h0001;
                nxt_tn   = 4'h0;
                nxt_ts   = {1'b1, tx_data, 1'b0};
                nxt_line = 1'b0;
            end
        end else if (tc_ff != 16'h0000) begin
            nxt_tc = tc_ff - 16'h0001;
        end else if (tn_ff == 4'h9) begin
            nxt_tb   = 1'b0;
            nxt_line = 1'b1;
        end else begin
            nxt_tc   = DIV - 16'h0001;
            nxt_tn   = tn_ff + 4'h1;
            nxt_ts   = {1'b1, ts_ff[9:1]};
            nxt_line = ts_ff[1];
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {tb_ff, tc_ff, tn_ff} <= '0;
            {ts_ff, line_ff}      <= {10'h3FF, 1'b1};
        end else begin
            {tb_ff, tc_ff, tn_ff, ts_ff, line_ff} <= {nxt_tb, nxt_tc, nxt_tn, nxt_ts, nxt_line};
        end
    end

    // ------------------------------------------------------------
    // Command sequencer and AXI master
    // ------------------------------------------------------------
    logic [63:0] buf_ff [256];
    uab_state_t  st_ff, nxt_st;
    uab_op_t     op_ff, nxt_op;
    logic [2:0]  cnt_ff, nxt_cnt;
    logic [31:0] addr_ff, nxt_addr;
    logic [63:0] data_ff, nxt_data;
    logic [3:0]  beat_ff, nxt_beat;
    logic [3:0]  burst_ff, nxt_burst;
    logic [10:0] idx_ff, nxt_idx;
    logic [7:0]  len_ff, nxt_len;
    logic        awv_ff, nxt_awv, wv_ff, nxt_wv, wl_ff, nxt_wl;
    logic        br_ff, nxt_br, arv_ff, nxt_arv, rr_ff, nxt_rr;
    logic        busy_ff, is_burst, last_burst;
    logic [63:0] send_word;

    assign is_burst   = (op_ff == UAB_OP_BWR) || (op_ff == UAB_OP_BRD);
    assign last_burst = !is_burst || (burst_ff == 4'(`UAB_BURSTS - 1));
    assign send_word  = is_burst ? buf_ff[idx_ff[10:3]] : data_ff;
    assign push_data  = send_word[{idx_ff[2:0], 3'h0} +: 8];
    assign push_valid = (st_ff == UAB_ST_SEND);

    always_comb begin
        nxt_st    = st_ff;
        nxt_op    = op_ff;
        {nxt_cnt, nxt_addr, nxt_data} = {cnt_ff, addr_ff, data_ff};
        {nxt_beat, nxt_burst, nxt_idx, nxt_len} = {beat_ff, burst_ff, idx_ff, len_ff};
        {nxt_awv, nxt_wv, nxt_wl} = {awv_ff, wv_ff, wl_ff};
        {nxt_br, nxt_arv, nxt_rr} = {br_ff, arv_ff, rr_ff};
        case (st_ff)
            UAB_ST_IDLE: begin
                if (rv_ff) begin
                    nxt_cnt = 3'h0;
                    nxt_st  = UAB_ST_ADDR;
                    if (rs_ff == `UAB_CMD_SWR) begin
                        nxt_op = UAB_OP_SWR;
                    end else if (rs_ff == `UAB_CMD_SRD) begin
                        nxt_op = UAB_OP_SRD;
                    end else if (rs_ff == `UAB_CMD_BWR) begin
                        nxt_op = UAB_OP_BWR;
                    end else if (rs_ff == `UAB_CMD_BRD) begin
                        nxt_op = UAB_OP_BRD;
                    end else begin
                        nxt_st = UAB_ST_IDLE;
                    end
                end
            end
            UAB_ST_ADDR: begin
                if (rv_ff) begin
                    nxt_addr = {addr_ff[23:0], rs_ff};
                    nxt_cnt  = cnt_ff + 3'h1;
                    nxt_len  = is_burst ? 8'(`UAB_BEATS - 1) : 8'h00;
                    nxt_burst = 4'h0;
                    nxt_beat = 4'h0;
                    if (cnt_ff == 3'(`UAB_ADDR_BYTES - 1)) begin
                        nxt_addr = {addr_ff[23:0], rs_ff} & `UAB_ALIGN_MASK;
                        nxt_cnt  = 3'h0;
                        if (op_ff == UAB_OP_SWR || op_ff == UAB_OP_BWR) begin
                            nxt_st = UAB_ST_DATA;
                        end else begin
                            nxt_arv = 1'b1;
                            nxt_st  = UAB_ST_AR;
                        end
                    end
                end
            end
            UAB_ST_DATA: begin
                if (rv_ff) begin
                    nxt_data = {data_ff[55:0], rs_ff};
                    nxt_cnt  = cnt_ff + 3'h1;
                    if (cnt_ff == 3'(`UAB_DATA_BYTES - 1)) begin
                        nxt_awv = 1'b1;
                        nxt_st  = UAB_ST_AW;
                    end
                end
            end
            UAB_ST_AW: begin
                if (awready_in) begin
                    nxt_awv  = 1'b0;
                    nxt_wv   = 1'b1;
                    nxt_wl   = (len_ff == 8'h00);
                    nxt_beat = 4'h0;
                    nxt_st   = UAB_ST_W;
                end
            end
            UAB_ST_W: begin
                if (wready_in) begin
                    nxt_data = data_ff + 64'h0000000000000001;
                    nxt_beat = beat_ff + 4'h1;
                    nxt_wl   = ({4'h0, beat_ff} + 8'h01 == len_ff);
                    if (wl_ff) begin
                        nxt_wv = 1'b0;
                        nxt_wl = 1'b0;
                        nxt_br = 1'b1;
                        nxt_st = UAB_ST_B;
                    end
                end
            end
            UAB_ST_B: begin
                if (bvalid_in) begin
                    nxt_br = 1'b0;
                    if (last_burst) begin
                        nxt_st = UAB_ST_IDLE;
                    end else begin
                        nxt_burst = burst_ff + 4'h1;
                        nxt_addr  = addr_ff + `UAB_BURST_BYTES;
                        nxt_awv   = 1'b1;
                        nxt_st    = UAB_ST_AW;
                    end
                end
            end
            UAB_ST_AR: begin
                if (arready_in) begin
                    nxt_arv  = 1'b0;
                    nxt_rr   = 1'b1;
                    nxt_beat = 4'h0;
                    nxt_st   = UAB_ST_R;
                end
            end
            UAB_ST_R: begin
                if (rvalid_in) begin
                    if (!is_burst) begin
                        nxt_data = rdata_in;
                    end
                    nxt_beat = beat_ff + 4'h1;
                    if (rlast_in) begin
                        nxt_rr = 1'b0;
                        if (last_burst) begin
                            nxt_idx = 11'h000;
                            nxt_st  = UAB_ST_SEND;
                        end else begin
                            nxt_burst = burst_ff + 4'h1;
                            nxt_addr  = addr_ff + `UAB_BURST_BYTES;
                            nxt_arv   = 1'b1;
                            nxt_st    = UAB_ST_AR;
                        end
                    end
                end
            end
            UAB_ST_SEND: begin
                if (push_ready) begin
                    nxt_idx = idx_ff + 11'h001;
                    if (idx_ff == (is_burst ? 11'h7FF : 11'h007)) begin
                        nxt_st = UAB_ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_st = UAB_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff    <= UAB_ST_IDLE;
            op_ff    <= UAB_OP_SWR;
            {cnt_ff, addr_ff, data_ff, beat_ff, burst_ff, idx_ff, len_ff} <= '0;
            {awv_ff, wv_ff, wl_ff, br_ff, arv_ff, rr_ff, busy_ff} <= '0;
        end else begin
            st_ff    <= nxt_st;
            op_ff    <= nxt_op;
            {cnt_ff, addr_ff, data_ff} <= {nxt_cnt, nxt_addr, nxt_data};
            {beat_ff, burst_ff, idx_ff, len_ff} <= {nxt_beat, nxt_burst, nxt_idx, nxt_len};
            {awv_ff, wv_ff, wl_ff} <= {nxt_awv, nxt_wv, nxt_wl};
            {br_ff, arv_ff, rr_ff} <= {nxt_br, nxt_arv, nxt_rr};
            busy_ff  <= (nxt_st != UAB_ST_IDLE);
        end
    end

    // Burst read buffer, one word per beat in address order
    always_ff @(posedge mclk_in) begin
        if (st_ff == UAB_ST_R && rvalid_in && is_burst) begin
            buf_ff[{burst_ff, beat_ff}] <= rdata_in;
        end
    end

    assign uart_tx_out = line_ff;
    assign busy_out    = busy_ff;
    assign awaddr_out  = addr_ff;
    assign awlen_out   = len_ff;
    assign awsize_out  = `UAB_AXSIZE;
    assign awburst_out = `UAB_AXBURST;
    assign awvalid_out = awv_ff;
    assign wdata_out   = data_ff;
    assign wstrb_out   = 8'hFF;
    assign wlast_out   = wl_ff;
    assign wvalid_out  = wv_ff;
    assign bready_out  = br_ff;
    assign araddr_out  = addr_ff;
    assign arlen_out   = len_ff;
    assign arsize_out  = `UAB_AXSIZE;
    assign arburst_out = `UAB_AXBURST;
    assign arvalid_out = arv_ff;
    assign rready_out  = rr_ff;
endmodule // uab_bridge

// ===== bench/uab_bridge_properties.sv
// Checker for the bridge's AXI request shape, ordering and serial quiet time.
// Assumes it is bound to uab_bridge and sees only that module's ports.
`timescale 1ns/1ps
`include "uab_consts.svh"
module uab_bridge_properties (
    input wire logic        mclk_in,
    input wire logic        rstn_in,
    input wire logic        uart_tx_out,
    input wire logic        busy_out,
    input wire logic [31:0] awaddr_out,
    input wire logic [7:0]  awlen_out,
    input wire logic [2:0]  awsize_out,
    input wire logic [7:0]  wstrb_out,
    input wire logic [2:0]  arsize_out,
    input wire logic [1:0]  arburst_out,
    input wire logic [1:0]  awburst_out,
    input wire logic        awvalid_out,
    input wire logic        awready_in,
    input wire logic [63:0] wdata_out,
    input wire logic        wlast_out,
    input wire logic        wvalid_out,
    input wire logic        wready_in,
    input wire logic [31:0] araddr_out,
    input wire logic [7:0]  arlen_out,
    input wire logic        arvalid_out,
    input wire logic        arready_in,
    input wire logic        rready_out
);
    logic [4:0]  hs_cnt_ff, nxt_hs_cnt, beat_ff, nxt_beat, len_ff, nxt_len;
    logic [31:0] aprev_ff, nxt_aprev;
    logic [63:0] wprev_ff, nxt_wprev;
    logic        wseen_ff, nxt_wseen, aw_hs, ar_hs, w_hs;

    // ----------------------------------------
    // Burst, beat and data tracking
    // ----------------------------------------
    always_comb begin
        aw_hs      = awvalid_out && awready_in;
        ar_hs      = arvalid_out && arready_in;
        w_hs       = wvalid_out && wready_in;
        nxt_hs_cnt = busy_out ? hs_cnt_ff + 5'(aw_hs || ar_hs) : 5'h00;
        nxt_len    = aw_hs ? awlen_out[4:0] : len_ff;
        nxt_beat   = aw_hs ? 5'h00 : beat_ff + 5'(w_hs);
        nxt_aprev  = aw_hs ? awaddr_out : (ar_hs ? araddr_out : aprev_ff);
        nxt_wseen  = busy_out && (wseen_ff || w_hs);
        nxt_wprev  = w_hs ? wdata_out : wprev_ff;
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {hs_cnt_ff, len_ff, beat_ff, aprev_ff, wseen_ff, wprev_ff} <= '0;
        end else begin
            {hs_cnt_ff, len_ff, beat_ff} <= {nxt_hs_cnt, nxt_len, nxt_beat};
            {aprev_ff, wseen_ff, wprev_ff} <= {nxt_aprev, nxt_wseen, nxt_wprev};
        end
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_aw_hs; awvalid_out && awready_in; endsequence
    sequence s_ar_hs; arvalid_out && arready_in; endsequence

    a_aw_held: assert property (awvalid_out && !awready_in |=> awvalid_out
        && $stable(awaddr_out) && $stable(awlen_out)) else $error("aw request not held");
    a_aw_shape: assert property (awvalid_out |-> awaddr_out[2:0] == 3'h0
        && awsize_out == `UAB_AXSIZE && awburst_out == `UAB_AXBURST && wstrb_out == 8'hFF
        && (awlen_out == 8'h00 || awlen_out == 8'h0F)) else $error("bad write request shape");
    a_ar_shape: assert property (arvalid_out |-> araddr_out[2:0] == 3'h0
        && arsize_out == `UAB_AXSIZE && arburst_out == `UAB_AXBURST
        && (arlen_out == 8'h00 || arlen_out == 8'h0F)) else $error("bad read request shape");
    a_w_follows: assert property (s_aw_hs |=> wvalid_out) else $error("write beat late");
    a_r_follows: assert property (s_ar_hs |=> rready_out) else $error("read ready late");
    a_wlast_count: assert property (wvalid_out |-> wlast_out == (beat_ff == len_ff))
        else $error("last beat flag misplaced");
    a_wdata_incr: assert property (wvalid_out && wready_in && wseen_ff
        |-> wdata_out == wprev_ff + 64'h1) else $error("write data not incremented");
    a_aw_step: assert property (awvalid_out && awready_in && hs_cnt_ff != 5'h00
        |-> awaddr_out == aprev_ff + `UAB_BURST_BYTES) else $error("write burst address step");
    a_ar_step: assert property (arvalid_out && arready_in && hs_cnt_ff != 5'h00
        |-> araddr_out == aprev_ff + `UAB_BURST_BYTES) else $error("read burst address step");
    a_burst_total: assert property ($fell(busy_out)
        |-> hs_cnt_ff == 5'h01 || hs_cnt_ff == 5'h10) else $error("wrong burst count");
    a_tx_quiet: assert property (rready_out |-> uart_tx_out)
        else $error("reply started during read");
endmodule // uab_bridge_properties

bind uab_bridge uab_bridge_properties u_props (.*);

// ===== bench/uab_mem_model.sv
// Behavioural AXI memory slave facing the bridge.
// Assumes 64-bit words; slow_in adds stalls on the AW, W, AR and R channels, not on B.
`timescale 1ns/1ps
module uab_mem_model (
    input  wire logic        mclk_in,
    input  wire logic        slow_in,
    input  wire logic [31:0] awaddr_in,
    input  wire logic [7:0]  awlen_in,
    input  wire logic        awvalid_in,
    output logic             awready_out,
    input  wire logic [63:0] wdata_in,
    input  wire logic        wvalid_in,
    output logic             wready_out,
    output logic [1:0]       bresp_out,
    output logic             bvalid_out,
    input  wire logic        bready_in,
    input  wire logic [31:0] araddr_in,
    input  wire logic [7:0]  arlen_in,
    input  wire logic        arvalid_in,
    output logic             arready_out,
    output logic [63:0]      rdata_out,
    output logic             rlast_out,
    output logic             rvalid_out,
    input  wire logic        rready_in
);
    logic [63:0] mem [logic [28:0]];
    logic [28:0] wa, ra;
    int          nw, nr;

    initial begin
        {awready_out, wready_out, bvalid_out, bresp_out} = '0;
        forever begin
            @(posedge mclk_in);
            if (awvalid_in) begin
                if (slow_in) repeat (3) @(posedge mclk_in);
                awready_out <= 1'b1;
                @(posedge mclk_in);
                awready_out <= 1'b0;
                wa = awaddr_in[31:3];
                nw = int'(awlen_in);
                for (int k = 0; k <= nw; k++) begin
                    wready_out <= 1'b1;
                    do @(posedge mclk_in); while (!wvalid_in);
                    mem[wa] = wdata_in;
                    wa++;
                    if (slow_in) begin
                        wready_out <= 1'b0;
                        @(posedge mclk_in);
                    end
                end
                wready_out <= 1'b0;
                bvalid_out <= 1'b1;
                do @(posedge mclk_in); while (!bready_in);
                bvalid_out <= 1'b0;
            end
        end
    end

    initial begin
        {arready_out, rvalid_out, rlast_out} = '0;
        rdata_out = 64'h0;
        forever begin
            @(posedge mclk_in);
            // Idle data keeps changing
            rdata_out <= ~rdata_out;
            if (arvalid_in) begin
                if (slow_in) repeat (2) @(posedge mclk_in);
                arready_out <= 1'b1;
                @(posedge mclk_in);
                arready_out <= 1'b0;
                ra = araddr_in[31:3];
                nr = int'(arlen_in);
                for (int k = 0; k <= nr; k++) begin
                    rvalid_out <= 1'b1;
                    rlast_out <= (k == nr);
                    rdata_out <= mem.exists(ra) ? mem[ra] : {35'h0, ra};
                    do @(posedge mclk_in); while (!rready_in);
                    ra++;
                    if (slow_in) begin
                        {rvalid_out, rlast_out} <= 2'b00;
                        @(posedge mclk_in);
                    end
                end
                {rvalid_out, rlast_out} <= 2'b00;
            end
        end
    end
endmodule // uab_mem_model

// ===== bench/uart_axi_memory_test_bridge_test.sv
// Self-checking bench: serial host driver and receiver around the bridge.
// Assumes the memory model and the bound checker; baud divisor shrunk to 4.
`timescale 1ns/1ps
`include "uab_consts.svh"
module uart_axi_memory_test_bridge_test;
    localparam int DIV = 4;
    logic        mclk_in = 1'b0;
    logic        rstn_in, uart_rx_in, slow_mode, uart_tx, busy, rlast;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, araddr, addr;
    logic [7:0]  awlen, arlen, rx_b;
    logic [63:0] wdata, rdata, data;
    logic [1:0]  bresp;
    int          error_cnt = 0, cmp_count = 0, i, j, seed;

    always #10 mclk_in = ~mclk_in;

    uab_bridge #(.CLK_HZ(400), .BAUD(100)) u_dut (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .uart_rx_in(uart_rx_in), .uart_tx_out(uart_tx),
        .busy_out(busy), .awaddr_out(awaddr), .awlen_out(awlen), .awsize_out(),
        .awburst_out(), .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata),
        .wstrb_out(), .wlast_out(), .wvalid_out(wvalid), .wready_in(wready),
        .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr),
        .arlen_out(arlen), .arsize_out(), .arburst_out(), .arvalid_out(arvalid),
        .arready_in(arready), .rdata_in(rdata), .rlast_in(rlast), .rvalid_in(rvalid),
        .rready_out(rready));

    uab_mem_model u_mem (
        .mclk_in(mclk_in), .slow_in(slow_mode), .awaddr_in(awaddr), .awlen_in(awlen),
        .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata), .wvalid_in(wvalid),
        .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
        .araddr_in(araddr), .arlen_in(arlen), .arvalid_in(arvalid), .arready_out(arready),
        .rdata_out(rdata), .rlast_out(rlast), .rvalid_out(rvalid), .rready_in(rready));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] exp_byte(input logic [63:0] d0, input int n);
        logic [63:0] w;
        w = d0 + 64'(n / 8);
        return w[8*(n%8)+:8];
    endfunction

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int k = 0; k < 10; k++) begin
            uart_rx_in <= f[k];
            repeat (DIV) @(posedge mclk_in);
        end
    endtask

    task automatic send_cmd(input logic [7:0] op, input logic [31:0] a, input logic [63:0] d);
        @(posedge mclk_in);
        send_byte(op);
        for (int k = 3; k >= 0; k--) send_byte(a[8*k+:8]);
        if (op == `UAB_CMD_SWR || op == `UAB_CMD_BWR)
            for (int k = 7; k >= 0; k--) send_byte(d[8*k+:8]);
    endtask

    task automatic get_byte(output logic [7:0] b);
        for (int n = 0; n < 5000 && uart_tx !== 1'b0; n++) @(negedge mclk_in);
        repeat (DIV / 2) @(negedge mclk_in);
        for (int k = 0; k < 8; k++) begin
            repeat (DIV) @(negedge mclk_in);
            b[k] = uart_tx;
        end
        repeat (DIV) @(negedge mclk_in);
        chk(uart_tx, 64'h1);
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 20000 && busy !== 1'b0; n++) @(negedge mclk_in);
        chk(busy, 64'h0);
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rstn_in = 1'b0;
        uart_rx_in = 1'b1;
        slow_mode = 1'b0;
        seed = $urandom(4);
        repeat (6) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        send_byte(8'h55);
        repeat (DIV * 4) @(posedge mclk_in);
        chk(busy, 64'h0);
        for (i = 0; i < 4; i++) begin
            addr = (i == 3) ? 32'h03FFFFF8 : ($urandom & 32'h03FFFFF8);
            data = {$urandom, $urandom};
            slow_mode <= i[0];
            send_cmd(`UAB_CMD_SWR, addr, data);
            wait_idle();
            chk(u_mem.mem[addr[31:3]], data);
            send_cmd(`UAB_CMD_SRD, addr, 64'h0);
            for (j = 0; j < 8; j++) begin
                get_byte(rx_b);
                chk(rx_b, data[8*j+:8]);
            end
            wait_idle();
        end
        addr = 32'h03FFF7F8;
        data = {$urandom, $urandom};
        slow_mode <= 1'b1;
        send_cmd(`UAB_CMD_BWR, addr, data);
        wait_idle();
        for (j = 0; j < 256; j++) chk(u_mem.mem[addr[31:3] + 29'(j)], data + 64'(j));
        send_cmd(`UAB_CMD_BRD, addr, 64'h0);
        for (j = 0; j < 2048; j++) begin
            get_byte(rx_b);
            chk(rx_b, exp_byte(data, j));
        end
        wait_idle();
        results();
    end

    initial begin
        repeat (99000) @(posedge mclk_in);
        error_cnt++;
        results();
    end
endmodule // uart_axi_memory_test_bridge_test
